/* src/rgn_pkg.sv */
// Constants and carrier types for the receive gain / noise configuration bank.
// Assumes one 100 MHz clock domain and a field-serial link decoder on that clock.
// What this block does
// - Hold 7-bit static receive gain code, read/write, reset from nonvolatile copy.
// - One read/write bit from nonvolatile copy enables dynamic gain; off means static only.
// - Hold 6-bit noise monitoring threshold, read/write, reset value 32.
// - Clamp echo thresholds below 6-bit noise floor up to it; below floor is noise.
// - Noise floor uses threshold coding so comparison needs no scaling.
// - Five unsigned 7-bit delta gain magnitudes, read/write, reset to 0.
// - Each magnitude has a sign bit, reset 0; 0 raises gain, 1 lowers it.
// - Five 4-bit delta time codes, read/write, reset to 0.
// - Dynamic index: sub 0..9 magnitude/sign pairs, sub 10..14 time codes.
// - Fields travel least significant bit first, lowest sub-index first.
// - Reset loads nonvolatile copies where they exist, fixed defaults elsewhere.
package rgn_pkg;

  // Configuration memory indices served here
  localparam logic [3:0] RGN_IDX_RX = 4'h7;
  localparam logic [3:0] RGN_IDX_DYN = 4'h8;

  // Field widths
  localparam int RGN_GAIN_W = 7;
  localparam int RGN_LVL_W = 6;
  localparam int RGN_STEP_W = 7;
  localparam int RGN_WHEN_W = 4;
  localparam int RGN_STEPS = 5;

  // Reset values of fields without a nonvolatile copy
  localparam logic [5:0] RGN_WATCH_RST = 6'h20;
  localparam logic [5:0] RGN_CLAMP_RST = 6'h04;
  localparam logic [6:0] RGN_STEP_RST = 7'h00;
  localparam logic [3:0] RGN_WHEN_RST = 4'h0;

  // Bit positions within the serial frame of index 7 (LSB first)
  localparam int RGN_RX_GAIN_LSB = 0;
  localparam int RGN_RX_DYN_BIT = 7;
  localparam int RGN_RX_WATCH_LSB = 8;
  localparam int RGN_RX_CLAMP_LSB = 14;
  localparam logic [5:0] RGN_RX_LEN = 6'h14;

  // Bit positions within the serial frame of index 8
  localparam int RGN_PAIR_BITS = 8;
  localparam int RGN_WHEN_BASE = 40;
  localparam logic [5:0] RGN_DYN_LEN = 6'h3C;
  localparam int RGN_FRAME_W = 60;

  // Settings of index 7
  typedef struct packed {
    logic [5:0] noise_clamp_level;
    logic [5:0] noise_watch_level;
    logic dyn_gain_on;
    logic [6:0] static_rx_gain;
  } rgn_rx_cfg_t;

  // One dynamic gain step
  typedef struct packed {
    logic [3:0] when;
    logic neg;
    logic [6:0] size;
  } rgn_step_t;

  // Transfer state
  typedef enum logic [1:0] {
    RGN_IDLE = 2'b00,
    RGN_READ = 2'b01,
    RGN_WRITE = 2'b10
  } rgn_state_t;

endpackage

/* src/rgn_field.sv */
// One configuration field: a register with reset preload and whole-field write.
// Assumes the parent decides when a complete field value is ready to commit.
`timescale 1ns/1ps
module rgn_field #(
  parameter int W = 7,
  parameter logic [W-1:0] RST = '0,
  parameter bit HAS_NV = 1'b0
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Nonvolatile copy, valid while reset is high
  input wire logic [W-1:0] nv_val,
  // Write port
  input wire logic wr_en,
  input wire logic [W-1:0] wr_val,
  // Stored value
  output logic [W-1:0] val_q
);

  logic [W-1:0] val_d;

  // Reset takes the nonvolatile copy if one exists, else the fixed default
  assign val_d = reset ? (HAS_NV ? nv_val : RST) : (wr_en ? wr_val : val_q);

  // Storage, frozen while ce is low
  always_ff @(posedge clk) begin
    if (ce) begin
      val_q <= val_d;
    end
  end

endmodule

/* src/rgn_cfg_bank.sv */
// Receive gain, noise and dynamic gain profile fields of the configuration memory.
// Assumes a link decoder on the same clock that frames each field-serial transfer.
`timescale 1ns/1ps
module rgn_cfg_bank
  import rgn_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Nonvolatile copies, sampled while reset is high
  input wire logic [6:0] nv_static_rx_gain,
  input wire logic nv_dyn_gain_on,
  // Transfer framing from the link decoder
  input wire logic xfer_start,
  input wire logic [3:0] xfer_index,
  input wire logic xfer_write,
  input wire logic xfer_end,
  // Bit stream
  input wire logic bit_strobe,
  input wire logic bit_wdata,
  output logic bit_rdata_q,
  output logic xfer_hit_q,
  output logic xfer_over_q,
  // Echo path comparisons
  input wire logic [5:0] echo_thr_in,
  input wire logic [5:0] echo_mag_in,
  input wire logic noise_mon_en,
  output logic [5:0] echo_thr_eff_q,
  output logic echo_is_noise_q,
  output logic noise_above_q,
  // Settings towards the analogue front end and gain sequencer
  output rgn_rx_cfg_t rx_cfg_q,
  output rgn_step_t [RGN_STEPS-1:0] steps_q,
  output logic dyn_active_q
);

  // Field values
  logic [6:0] gain_v;
  logic dyn_v;
  logic [5:0] watch_v;
  logic [5:0] clamp_v;
  logic [6:0] size_v [RGN_STEPS];
  logic neg_v [RGN_STEPS];
  logic [3:0] when_v [RGN_STEPS];

  // Transfer state
  rgn_state_t state_q;
  rgn_state_t state_d;
  logic [3:0] sel_q;
  logic [5:0] ptr_q;
  logic [5:0] ptr_d;
  logic [RGN_FRAME_W-1:0] wsh_q;
  logic [RGN_FRAME_W-1:0] wsh_d;

  // Link framing as seen here: the decoder gives one start pulse carrying the
  // index and direction, then single-cycle bit strobes, then one end pulse.
  // A read walks the frame image bit by bit; a write collects bits in a shift
  // image and commits only at the end pulse, so a frame cut short by the
  // master never leaves a half-written field behind.
  // Limitation: only one transfer is tracked at a time; a new start pulse
  // discards whatever the previous transfer had gathered.

  // Decoded transfer conditions
  wire sel_rx = (sel_q == RGN_IDX_RX);
  wire sel_dyn = (sel_q == RGN_IDX_DYN);
  wire start_hit = (xfer_index == RGN_IDX_RX) || (xfer_index == RGN_IDX_DYN);
  wire [5:0] frame_len = sel_rx ? RGN_RX_LEN : RGN_DYN_LEN;
  wire in_frame = (ptr_q < frame_len);
  wire busy = (state_q != RGN_IDLE);
  wire bit_take = busy && bit_strobe && in_frame;
  wire commit = (state_q == RGN_WRITE) && xfer_end;
  wire commit_rx = commit && sel_rx;
  wire commit_dyn = commit && sel_dyn;

  // Serial images of the two indices, lowest sub-index at bit 0
  logic [19:0] frame_rx;
  logic [RGN_FRAME_W-1:0] frame_dyn;

  // Index 7: gain, enable, noise threshold, floor from bit 0 upwards
  assign frame_rx[RGN_RX_GAIN_LSB +: RGN_GAIN_W] = gain_v;
  assign frame_rx[RGN_RX_DYN_BIT] = dyn_v;
  assign frame_rx[RGN_RX_WATCH_LSB +: RGN_LVL_W] = watch_v;
  assign frame_rx[RGN_RX_CLAMP_LSB +: RGN_LVL_W] = clamp_v;

  // Index 8: magnitude/sign pairs then time codes
  always_comb begin
    frame_dyn = '0;
    for (int k = 0; k < RGN_STEPS; k++) begin
      frame_dyn[k*RGN_PAIR_BITS +: RGN_STEP_W] = size_v[k];
      frame_dyn[k*RGN_PAIR_BITS + RGN_STEP_W] = neg_v[k];
      frame_dyn[RGN_WHEN_BASE + k*RGN_WHEN_W +: RGN_WHEN_W] = when_v[k];
    end
  end

  // Bit presented to the reader at the next pointer value; past the end it reads zero
  logic rd_bit;
  logic [5:0] rd_ptr;

  assign rd_ptr = ptr_d;
  assign rd_bit = (!(rd_ptr < frame_len)) ? 1'b0 :
                  sel_rx ? frame_rx[rd_ptr[4:0]] :
                  sel_dyn ? frame_dyn[rd_ptr] : 1'b0;

  // Transfer sequencing; a new start always restarts the frame
  always_comb begin
    state_d = state_q;
    ptr_d = ptr_q;
    wsh_d = wsh_q;
    if (xfer_start) begin
      // Foreign indices park the sequencer so their strobes are ignored
      state_d = !start_hit ? RGN_IDLE : (xfer_write ? RGN_WRITE : RGN_READ);
      ptr_d = '0;
    end else begin
      // The end pulse wins over a strobe in the same cycle
      unique case (state_q)
        RGN_IDLE: begin
          ptr_d = ptr_q;
        end
        RGN_READ: begin
          if (xfer_end) begin
            state_d = RGN_IDLE;
          end else if (bit_take) begin
            ptr_d = ptr_q + 6'h01;
          end
        end
        RGN_WRITE: begin
          if (xfer_end) begin
            state_d = RGN_IDLE;
          end else if (bit_take) begin
            wsh_d[ptr_q] = bit_wdata;
            ptr_d = ptr_q + 6'h01;
          end
        end
        default: begin
          state_d = RGN_IDLE;
        end
      endcase
    end
  end

  // Transfer registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= RGN_IDLE;
      sel_q <= 4'h0;
      ptr_q <= 6'h00;
      wsh_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
      ptr_q <= ptr_d;
      wsh_q <= wsh_d;
      if (xfer_start) begin
        sel_q <= xfer_index;
      end
    end
  end

  // First bit of the addressed frame, shown the cycle after the start pulse
  wire start_bit = (xfer_index == RGN_IDX_RX) ? frame_rx[0] :
                   (xfer_index == RGN_IDX_DYN) ? frame_dyn[0] : 1'b0;
  wire strobe_over = busy && bit_strobe && !in_frame;

  // Read data is prefetched from the next pointer so it leads the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      bit_rdata_q <= 1'b0;
    end else if (ce) begin
      if (xfer_start) begin
        bit_rdata_q <= start_bit;
      end else if (busy) begin
        bit_rdata_q <= rd_bit;
      end
    end
  end

  // Hit flag stands from the start pulse until the end pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      xfer_hit_q <= 1'b0;
    end else if (ce) begin
      if (xfer_start) begin
        xfer_hit_q <= start_hit;
      end else if (busy && xfer_end) begin
        xfer_hit_q <= 1'b0;
      end
    end
  end

  // Overrun flag; extra bits beyond the frame are dropped rather than wrapped
  always_ff @(posedge clk) begin
    if (reset) begin
      xfer_over_q <= 1'b0;
    end else if (ce) begin
      if (xfer_start) begin
        xfer_over_q <= 1'b0;
      end else if (strobe_over) begin
        xfer_over_q <= 1'b1;
      end
    end
  end

  // Bit count after which each index 7 field is complete
  wire [5:0] end_gain = 6'(RGN_RX_GAIN_LSB + RGN_GAIN_W);
  wire [5:0] end_dyn = 6'(RGN_RX_DYN_BIT + 1);
  wire [5:0] end_watch = 6'(RGN_RX_WATCH_LSB + RGN_LVL_W);
  wire [5:0] end_clamp = 6'(RGN_RX_CLAMP_LSB + RGN_LVL_W);

  // A field commits only if all of its bits arrived; a short write keeps the rest
  wire wr_gain = commit_rx && (ptr_q >= end_gain);
  wire wr_dyn = commit_rx && (ptr_q >= end_dyn);
  wire wr_watch = commit_rx && (ptr_q >= end_watch);
  wire wr_clamp = commit_rx && (ptr_q >= end_clamp);

  // Index 7 fields
  rgn_field #(.W(RGN_GAIN_W), .RST(7'h00), .HAS_NV(1'b1)) u_gain (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .nv_val(nv_static_rx_gain),
    .wr_en(wr_gain),
    .wr_val(wsh_q[RGN_RX_GAIN_LSB +: RGN_GAIN_W]),
    .val_q(gain_v)
  );

  rgn_field #(.W(1), .RST(1'b0), .HAS_NV(1'b1)) u_dyn (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .nv_val(nv_dyn_gain_on),
    .wr_en(wr_dyn),
    .wr_val(wsh_q[RGN_RX_DYN_BIT]),
    .val_q(dyn_v)
  );

  rgn_field #(.W(RGN_LVL_W), .RST(RGN_WATCH_RST), .HAS_NV(1'b0)) u_watch (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .nv_val(RGN_WATCH_RST),
    .wr_en(wr_watch),
    .wr_val(wsh_q[RGN_RX_WATCH_LSB +: RGN_LVL_W]),
    .val_q(watch_v)
  );

  rgn_field #(.W(RGN_LVL_W), .RST(RGN_CLAMP_RST), .HAS_NV(1'b0)) u_clamp (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .nv_val(RGN_CLAMP_RST),
    .wr_en(wr_clamp),
    .wr_val(wsh_q[RGN_RX_CLAMP_LSB +: RGN_LVL_W]),
    .val_q(clamp_v)
  );

  // Index 8 fields, one magnitude, sign and time code per step
  for (genvar k = 0; k < RGN_STEPS; k++) begin : g_step
    wire wr_size = commit_dyn && (ptr_q >= 6'(k*RGN_PAIR_BITS + RGN_STEP_W));
    wire wr_neg = commit_dyn && (ptr_q >= 6'(k*RGN_PAIR_BITS + RGN_PAIR_BITS));
    wire wr_when = commit_dyn && (ptr_q >= 6'(RGN_WHEN_BASE + (k+1)*RGN_WHEN_W));

    rgn_field #(.W(RGN_STEP_W), .RST(RGN_STEP_RST), .HAS_NV(1'b0)) u_size (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .nv_val(RGN_STEP_RST),
      .wr_en(wr_size),
      .wr_val(wsh_q[k*RGN_PAIR_BITS +: RGN_STEP_W]),
      .val_q(size_v[k])
    );

    rgn_field #(.W(1), .RST(1'b0), .HAS_NV(1'b0)) u_neg (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .nv_val(1'b0),
      .wr_en(wr_neg),
      .wr_val(wsh_q[k*RGN_PAIR_BITS + RGN_STEP_W]),
      .val_q(neg_v[k])
    );

    rgn_field #(.W(RGN_WHEN_W), .RST(RGN_WHEN_RST), .HAS_NV(1'b0)) u_when (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .nv_val(RGN_WHEN_RST),
      .wr_en(wr_when),
      .wr_val(wsh_q[RGN_WHEN_BASE + k*RGN_WHEN_W +: RGN_WHEN_W]),
      .val_q(when_v[k])
    );
  end

  // Floor and thresholds share one coding, so a plain compare suffices
  wire thr_low = (echo_thr_in < clamp_v);
  wire mag_low = (echo_mag_in < clamp_v);
  wire mag_over_watch = (echo_mag_in > watch_v);

  // Echo path results, registered so the outputs come from flops
  always_ff @(posedge clk) begin
    if (reset) begin
      echo_thr_eff_q <= RGN_CLAMP_RST;
      echo_is_noise_q <= 1'b0;
      noise_above_q <= 1'b0;
    end else if (ce) begin
      echo_thr_eff_q <= thr_low ? clamp_v : echo_thr_in;
      echo_is_noise_q <= mag_low;
      noise_above_q <= noise_mon_en && mag_over_watch;
    end
  end

  // Index 7 settings copy; one cycle behind the fields, which costs nothing
  // at the front end and keeps every output on a flop
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_cfg_q <= '0;
      dyn_active_q <= 1'b0;
    end else if (ce) begin
      rx_cfg_q <= {clamp_v, watch_v, dyn_v, gain_v};
      dyn_active_q <= dyn_v;
    end
  end

  // Step profile copy; with dynamic gain off the sequencer sees a flat profile
  always_ff @(posedge clk) begin
    if (reset) begin
      steps_q <= '0;
    end else if (ce) begin
      for (int k = 0; k < RGN_STEPS; k++) begin
        steps_q[k].size <= dyn_v ? size_v[k] : 7'h00;
        steps_q[k].neg <= dyn_v ? neg_v[k] : 1'b0;
        steps_q[k].when <= when_v[k];
      end
    end
  end

endmodule

/* tb/rgn_cfg_bank_assertions.sv */
// Port-level checks for the receive gain and noise configuration bank.
// Assumes one clock domain with clock enable held high by the bench.
`timescale 1ns/1ps
module rgn_cfg_bank_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Transfer group
  input wire logic xfer_start,
  input wire logic [3:0] xfer_index,
  input wire logic xfer_end,
  input wire logic bit_strobe,
  input wire logic bit_rdata_q,
  input wire logic xfer_hit_q,
  input wire logic xfer_over_q,
  // Echo group and settings copy
  input wire logic [5:0] echo_thr_in,
  input wire logic [5:0] echo_mag_in,
  input wire logic noise_mon_en,
  input wire logic [5:0] echo_thr_eff_q,
  input wire logic echo_is_noise_q,
  input wire logic noise_above_q,
  input wire rgn_pkg::rgn_rx_cfg_t rx_cfg_q
);
  import rgn_pkg::*;
  logic [1:0] up_q;
  wire idx_ok = xfer_index == RGN_IDX_RX || xfer_index == RGN_IDX_DYN;
  // Copies lag the fields after reset, so value checks wait three edges
  always_ff @(posedge clk) begin
    if (reset) begin
      up_q <= 2'h0;
    end else if (up_q != 2'h3) begin
      up_q <= up_q + 2'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  floor_clamp_a: assert property (up_q == 2'h3 |-> echo_thr_eff_q == (($past(echo_thr_in) >
    rx_cfg_q.noise_clamp_level) ? $past(echo_thr_in) : rx_cfg_q.noise_clamp_level)) else $error("clamp wrong");
  below_floor_a: assert property (up_q == 2'h3 |-> echo_is_noise_q ==
    ($past(echo_mag_in) < rx_cfg_q.noise_clamp_level)) else $error("noise flag wrong");
  noise_watch_a: assert property (up_q == 2'h3 |-> noise_above_q ==
    ($past(noise_mon_en) && $past(echo_mag_in) > rx_cfg_q.noise_watch_level)) else $error("watch flag wrong");
  fields_hold_a: assert property (up_q == 2'h3 && !$past(xfer_end, 2) |-> $stable(rx_cfg_q))
    else $error("settings moved without write");
  index_hit_a: assert property (xfer_start && idx_ok |=> xfer_hit_q) else $error("hit missing");
  index_miss_a: assert property (xfer_start && !idx_ok |=> !xfer_hit_q && !bit_rdata_q)
    else $error("foreign index answered");
  hit_clear_a: assert property (xfer_end && !xfer_start |=> !xfer_hit_q) else $error("hit stuck");
  over_clear_a: assert property (xfer_start |=> !xfer_over_q) else $error("overrun stuck");
  read_bit_hold_a: assert property (!xfer_start && !bit_strobe |=> $stable(bit_rdata_q))
    else $error("read bit moved");
endmodule
bind rgn_cfg_bank rgn_cfg_bank_assertions i_chk (.clk, .reset, .xfer_start, .xfer_index, .xfer_end,
  .bit_strobe, .bit_rdata_q, .xfer_hit_q, .xfer_over_q, .echo_thr_in, .echo_mag_in, .noise_mon_en,
  .echo_thr_eff_q, .echo_is_noise_q, .noise_above_q, .rx_cfg_q);

/* tb/rgn_master_model.sv */
// Behavioural link master that frames field-serial transfers into the bank.
// Assumes the bank samples on the rising edge; everything moves 1 ns after it.
`timescale 1ns/1ps
module rgn_master_model (
  // Clock
  input wire logic clk,
  // Framing and bit stream
  output logic xfer_start,
  output logic [3:0] xfer_index,
  output logic xfer_write,
  output logic xfer_end,
  output logic bit_strobe,
  output logic bit_wdata,
  input wire logic bit_rdata_q
);
  initial begin
    {xfer_start, xfer_index, xfer_write, xfer_end, bit_strobe, bit_wdata} = '0;
  end
  // One whole transfer; slow leaves an idle cycle after every bit
  task automatic xfer(input logic [3:0] idx, input logic wr, input int n, input bit slow,
                      input logic [63:0] w, output logic [63:0] r);
    r = '0;
    @(posedge clk) #1;
    xfer_start = 1'b1;
    xfer_index = idx;
    xfer_write = wr;
    @(posedge clk) #1;
    xfer_start = 1'b0;
    xfer_index = ~idx; // Index is only qualified by the start pulse
    for (int i = 0; i < n; i++) begin
      r[i] = bit_rdata_q;
      bit_strobe = 1'b1;
      bit_wdata = w[i];
      @(posedge clk) #1;
      if (slow || i == n - 1) begin
        bit_strobe = 1'b0;
        bit_wdata = ~w[i]; // Released line never shows the stale bit
        if (slow) @(posedge clk) #1;
      end
    end
    xfer_end = 1'b1;
    @(posedge clk) #1;
    xfer_end = 1'b0;
  endtask
endmodule

/* tb/rgn_cfg_bank_tb_top.sv */
// Self-checking bench for the receive gain and noise configuration bank.
// Assumes the package, checker and link master model are compiled first.
`timescale 1ns/1ps
module rgn_cfg_bank_tb_top;
  import rgn_pkg::*;
  logic clk, reset, ce, nv_dyn_gain_on, xfer_start, xfer_write, xfer_end, bit_strobe, bit_wdata;
  logic noise_mon_en, bit_rdata_q, xfer_hit_q, xfer_over_q, echo_is_noise_q, noise_above_q, dyn_active_q;
  logic [3:0] xfer_index;
  logic [6:0] nv_static_rx_gain;
  logic [5:0] echo_thr_in, echo_mag_in, echo_thr_eff_q;
  rgn_rx_cfg_t rx_cfg_q;
  rgn_step_t [RGN_STEPS-1:0] steps_q;
  logic [63:0] rd, wr7, wr8;
  int errors = 0;
  int n_compared = 0;
  rgn_cfg_bank i_dut (.clk, .reset, .ce, .nv_static_rx_gain, .nv_dyn_gain_on, .xfer_start, .xfer_index,
    .xfer_write, .xfer_end, .bit_strobe, .bit_wdata, .bit_rdata_q, .xfer_hit_q, .xfer_over_q, .echo_thr_in,
    .echo_mag_in, .noise_mon_en, .echo_thr_eff_q, .echo_is_noise_q, .noise_above_q, .rx_cfg_q, .steps_q,
    .dyn_active_q);
  rgn_master_model i_master (.clk, .xfer_start, .xfer_index, .xfer_write, .xfer_end, .bit_strobe,
    .bit_wdata, .bit_rdata_q);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Fresh echo operands each cycle; the checker judges the compares
  always @(posedge clk) begin
    #1;
    echo_thr_in = 6'($urandom);
    echo_mag_in = 6'($urandom);
    noise_mon_en = 1'($urandom);
  end
  function automatic logic [63:0] exp_steps(input logic [63:0] f, input logic dyn);
    exp_steps = '0;
    for (int k = 0; k < RGN_STEPS; k++) begin
      exp_steps[12*k +: 12] = {f[40+4*k +: 4], f[8*k+7] & dyn, f[8*k +: 7] & {7{dyn}}};
    end
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Reload from the nonvolatile copies, then look at the settled copies
  task automatic do_reset(input logic dyn);
    nv_static_rx_gain = 7'($urandom);
    nv_dyn_gain_on = dyn;
    reset = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(64'(rx_cfg_q), 64'({RGN_CLAMP_RST, RGN_WATCH_RST, dyn, nv_static_rx_gain}));
    chk(64'(steps_q), 64'h0);
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    close_out();
  end
  initial begin
    void'($urandom(90997));
    ce = 1'b1;
    {echo_thr_in, echo_mag_in, noise_mon_en} = '0;
    do_reset(1'b1);
    for (int t = 0; t < 8; t++) begin
      wr7 = t == 1 ? 64'h0 : (t == 2 ? '1 : {$urandom, $urandom});
      wr8 = t == 0 ? '1 : {$urandom, $urandom};
      i_master.xfer(RGN_IDX_RX, 1'b1, 20, t[0], wr7, rd);
      i_master.xfer(RGN_IDX_DYN, 1'b1, 60, t[1], wr8, rd);
      i_master.xfer(RGN_IDX_RX, 1'b0, 20, t[2], 64'h0, rd);
      chk(rd, wr7 & 64'hFFFFF);
      i_master.xfer(RGN_IDX_DYN, 1'b0, 60, 1'b0, 64'h0, rd);
      chk(rd, wr8 & 64'h0FFF_FFFF_FFFF_FFFF);
      chk(64'(rx_cfg_q), wr7 & 64'hFFFFF);
      chk(64'(dyn_active_q), 64'(wr7[7]));
      chk(64'(steps_q), exp_steps(wr8, wr7[7]));
    end
    // Cut-short write: gain and enable complete, threshold fields not
    wr8 = {$urandom, $urandom};
    i_master.xfer(RGN_IDX_RX, 1'b1, 10, 1'b0, wr8, rd);
    wr7 = {wr7[63:8], wr8[7:0]};
    i_master.xfer(RGN_IDX_RX, 1'b0, 22, 1'b0, 64'h0, rd);
    chk(rd, wr7 & 64'hFFFFF);
    chk(64'(xfer_over_q), 64'h1);
    // Foreign index is neither written nor answered
    i_master.xfer(4'h9, 1'b1, 20, 1'b0, wr8, rd);
    i_master.xfer(4'h9, 1'b0, 20, 1'b0, 64'h0, rd);
    chk(rd, 64'h0);
    chk(64'(rx_cfg_q), wr7 & 64'hFFFFF);
    do_reset(1'b0);
    close_out();
  end
endmodule
